/* src/tester_option_pkg.sv */
// Purpose: shared constants and types of the tester option command block
// Assumes: 32-bit APB register access, one word per register
// Notes: opcodes name the settings, a query flag selects set or read
package tester_option_pkg;

    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_ARG = 8'h04;
    localparam logic [7:0] OFS_CMD = 8'h08;
    localparam logic [7:0] OFS_STATUS = 8'h0C;
    localparam logic [7:0] OFS_SETTINGS = 8'h10;
    localparam logic [7:0] OFS_RESP = 8'h14;
    localparam logic [7:0] OFS_FMT = 8'h18;

    localparam int STAT_CMD_ERR = 0;
    localparam int STAT_EXE_ERR = 1;
    localparam int STAT_RESP_VALID = 2;
    localparam int STAT_POWER_ON = 7;

    localparam logic [1:0] MODE_SOFT = 2'h0;
    localparam logic [1:0] MODE_NORMAL = 2'h1;
    localparam logic [1:0] MODE_CONT = 2'h2;

    localparam logic [8:0] MAX_BINARY = 9'h001;
    localparam logic [8:0] MAX_LATCH = 9'h003;
    localparam logic [8:0] MAX_PRINT = 9'h002;
    localparam logic [8:0] MAX_MODE = 9'h002;

    localparam logic [1:0] CTRL_RESET = 2'h0;
    localparam logic [3:0] STATE_RESET = 4'h1;

    typedef enum logic [3:0] {
        ST_READY = 4'b0001,
        ST_OPTION = 4'b0010,
        ST_TEST = 4'b0100,
        ST_OTHER = 4'b1000
    } inst_state_t;

    typedef enum logic [3:0] {
        OP_PULSE = 4'h0,
        OP_LATCH = 4'h1,
        OP_PRINT = 4'h2,
        OP_MODE = 4'h3,
        OP_TIMER = 4'h4,
        OP_UNIT = 4'h5,
        OP_UPPER = 4'h6,
        OP_ENDLESS = 4'h7,
        OP_COUNT = 4'h8,
        OP_START = 4'h9
    } opcode_t;

    typedef enum logic [3:0] {
        WORD_NONE = 4'h0,
        WORD_ON = 4'h1,
        WORD_OFF = 4'h2,
        WORD_OHM = 4'h3,
        WORD_VOLT = 4'h4
    } word_t;

    typedef struct packed {
        logic is_char;
        word_t word;
        logic [7:0] value_int;
        logic [7:0] value_frac;
    } arg_t;

    typedef struct packed {
        logic count_en;
        logic endless;
        logic upper_en;
        logic unit_volt;
        logic timer_en;
        logic [1:0] test_mode;
        logic [1:0] print_mode;
        logic [1:0] pass_fail_latch_option;
        logic pulse_out;
    } settings_t;

    localparam settings_t SETTINGS_RESET = 12'h002;

    typedef struct packed {
        logic header_on;
        logic is_char;
        logic [1:0] pad;
        opcode_t path;
        logic [7:0] pad2;
        logic [15:0] value;
    } resp_t;

    typedef struct packed {
        logic [2:0] kind;
        logic fixed_point_numeric_format;
        logic [3:0] max_digits;
        logic [3:0] min_digits;
    } fmt_t;

endpackage : tester_option_pkg

/* src/tester_option_command_set.sv */
// Purpose: option and test-limit command interpreter behind an APB slave
// Assumes: ARG is written before CMD; a CMD write marks a whole message received
// Notes: zero wait states, unmapped addresses answer with pslverr
// Notes on behaviour
// - pulse-output option takes 0 (off) or 1 (on) and is stored
// - numeric value outside its list gives execution error, setting kept
// - fractional numeric values are rounded before range check and use
// - settings only execute in ready or option screen, else execution error
// - enabling pulse output in continuous mode is refused with execution error
// - a link start runs the test with pulse output disabled
// - queries return stored value and command path, marked with the header setting
// - pass/fail latch takes 0 to 3 with four latch combinations
// - print option takes 0 to 2: unused, automatic, selective
// - test mode takes 0 soft, 1 normal, 2 continuous; query same code
// - selecting continuous mode clears an enabled pulse output option
// - test duration enable takes ON or OFF and reads back ON or OFF
// - bad word on a character command gives a command error
// - endless option makes the test ignore the duration enable
// - limit quantity OHM applies resistance limits, VOLT voltage limits
// - upper limit enable takes ON or OFF and reads back ON or OFF
// - voltage responses three digits fixed, resistance four digits fixed
// - current two or three digits, time two to four digits, fixed
// - test data count reported as integer of one or two digits
// - power-on clears event bits but leaves power-on flag bit 7 set
// - count limit is not applied while the count option is off
`timescale 1ns/10ps
module tester_option_command_set
    import tester_option_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic panel_start,
    output logic run_start,
    output logic run_pulse_en,
    output logic run_timer_en,
    output logic run_limit_volt,
    output logic run_upper_en,
    output logic run_count_apply
);

    if (ADDR_W < 5) begin : g_bad_width
        $error("ADDR_W too small for the register map");
    end

    logic header_on;
    inst_state_t inst_state;
    arg_t arg;
    settings_t settings;
    settings_t next_settings;
    resp_t resp;
    fmt_t fmt;
    logic [2:0] fmt_kind;
    logic cmd_err_flag;
    logic exe_err_flag;
    logic resp_valid;
    logic power_on_flag;

    // bus decode
    wire [7:0] addr8 = 8'(paddr);
    wire setup_rd = psel && !penable && !pwrite;
    wire access = psel && penable;
    wire wr = access && pwrite;
    wire rd = access && !pwrite;
    wire hit_ctrl = addr8 == OFS_CTRL;
    wire hit_arg = addr8 == OFS_ARG;
    wire hit_cmd = addr8 == OFS_CMD;
    wire hit_status = addr8 == OFS_STATUS;
    wire hit_settings = addr8 == OFS_SETTINGS;
    wire hit_resp = addr8 == OFS_RESP;
    wire hit_fmt = addr8 == OFS_FMT;
    wire mapped = hit_ctrl || hit_arg || hit_cmd || hit_status || hit_settings
        || hit_resp || hit_fmt;
    wire full_word = pstrb == 4'hF;

    assign pready = 1'b1;
    assign pslverr = access && !mapped;

    // command decode
    wire exec = wr && hit_cmd && full_word;
    wire is_query = pwdata[4];
    wire [3:0] op_raw = pwdata[3:0];
    wire op_known = op_raw <= OP_START;
    wire op_char = op_raw == OP_TIMER || op_raw == OP_UNIT || op_raw == OP_UPPER;
    wire op_num = op_known && !op_char && op_raw != OP_START;

    // round half up on the fraction before any range test
    wire [8:0] rounded = {1'b0, arg.value_int} + {8'h00, arg.value_frac[7]};

    logic [8:0] op_max;
    always_comb begin
        op_max = MAX_BINARY;
        if (op_raw == OP_LATCH) begin
            op_max = MAX_LATCH;
        end else if (op_raw == OP_PRINT) begin
            op_max = MAX_PRINT;
        end else if (op_raw == OP_MODE) begin
            op_max = MAX_MODE;
        end
    end

    wire num_ok = !arg.is_char && rounded <= op_max;
    wire onoff_word = arg.word == WORD_ON || arg.word == WORD_OFF;
    wire unit_word = arg.word == WORD_OHM || arg.word == WORD_VOLT;
    wire char_ok = arg.is_char && (op_raw == OP_UNIT ? unit_word : onoff_word);
    wire state_ok = inst_state == ST_READY || inst_state == ST_OPTION;
    wire in_cont = settings.test_mode == MODE_CONT;
    wire pulse_block = op_raw == OP_PULSE && rounded[0] && in_cont;

    // a bad word is a command error and outranks the state check
    wire bad_cmd = !op_known || (is_query && op_raw == OP_START)
        || (!is_query && op_char && !char_ok);
    wire bad_state = op_raw == OP_START ? inst_state != ST_READY : !state_ok;
    wire bad_exe = !is_query && !bad_cmd && (bad_state
        || (op_num && !num_ok)
        || (op_num && pulse_block));
    wire set_cmd_err = exec && bad_cmd;
    wire set_exe_err = exec && bad_exe;
    wire apply = exec && !is_query && !bad_cmd && !bad_exe;
    wire do_query = exec && is_query && !bad_cmd;
    wire link_start = apply && op_raw == OP_START;
    wire word_on = arg.word == WORD_ON;

    always_comb begin
        next_settings = settings;
        if (apply) begin
            case (op_raw)
                OP_PULSE: next_settings.pulse_out = rounded[0];
                OP_LATCH: next_settings.pass_fail_latch_option = rounded[1:0];
                OP_PRINT: next_settings.print_mode = rounded[1:0];
                OP_MODE: begin
                    next_settings.test_mode = rounded[1:0];
                    if (rounded[1:0] == MODE_CONT) begin
                        next_settings.pulse_out = 1'b0;
                    end
                end
                OP_TIMER: next_settings.timer_en = word_on;
                OP_UNIT: next_settings.unit_volt = arg.word == WORD_VOLT;
                OP_UPPER: next_settings.upper_en = word_on;
                OP_ENDLESS: next_settings.endless = rounded[0];
                OP_COUNT: next_settings.count_en = rounded[0];
                default: next_settings = settings;
            endcase
        end
    end

    // query answer, built from stored values only
    logic [15:0] q_value;
    always_comb begin
        q_value = 16'h0000;
        case (op_raw)
            OP_PULSE: q_value = {15'h0000, settings.pulse_out};
            OP_LATCH: q_value = {14'h0000, settings.pass_fail_latch_option};
            OP_PRINT: q_value = {14'h0000, settings.print_mode};
            OP_MODE: q_value = {14'h0000, settings.test_mode};
            OP_TIMER: q_value = {12'h000, settings.timer_en ? WORD_ON : WORD_OFF};
            OP_UNIT: q_value = {12'h000, settings.unit_volt ? WORD_VOLT : WORD_OHM};
            OP_UPPER: q_value = {12'h000, settings.upper_en ? WORD_ON : WORD_OFF};
            OP_ENDLESS: q_value = {15'h0000, settings.endless};
            OP_COUNT: q_value = {15'h0000, settings.count_en};
            default: q_value = 16'h0000;
        endcase
    end

    resp_t next_resp;
    always_comb begin
        next_resp = '0;
        next_resp.header_on = header_on;
        next_resp.is_char = op_char;
        next_resp.path = opcode_t'(op_raw);
        next_resp.value = q_value;
    end

    // digit and style table for numeric answers
    fmt_t next_fmt;
    always_comb begin
        next_fmt = '0;
        next_fmt.kind = fmt_kind;
        next_fmt.fixed_point_numeric_format = 1'b1;
        case (fmt_kind)
            3'h0: begin
                next_fmt.min_digits = 4'h2;
                next_fmt.max_digits = 4'h3;
            end
            3'h1: begin
                next_fmt.min_digits = 4'h3;
                next_fmt.max_digits = 4'h3;
            end
            3'h2: begin
                next_fmt.min_digits = 4'h4;
                next_fmt.max_digits = 4'h4;
            end
            3'h3: begin
                next_fmt.min_digits = 4'h2;
                next_fmt.max_digits = 4'h4;
            end
            3'h4: begin
                next_fmt.fixed_point_numeric_format = 1'b0;
                next_fmt.min_digits = 4'h1;
                next_fmt.max_digits = 4'h2;
            end
            default: next_fmt.fixed_point_numeric_format = 1'b0;
        endcase
    end

    wire clr_status = wr && hit_status && pstrb[0];
    wire rd_resp = rd && hit_resp;
    wire [31:0] status_word = {24'h000000, power_on_flag, 4'h0, resp_valid,
        exe_err_flag, cmd_err_flag};

    logic [31:0] rd_word;
    always_comb begin
        rd_word = 32'h00000000;
        if (hit_ctrl) begin
            rd_word = {27'h0000000, inst_state, header_on};
        end else if (hit_arg) begin
            rd_word = {11'h000, arg};
        end else if (hit_status) begin
            rd_word = status_word;
        end else if (hit_settings) begin
            rd_word = {20'h00000, settings};
        end else if (hit_resp) begin
            rd_word = resp;
        end else if (hit_fmt) begin
            rd_word = {13'h0000, fmt.kind, 4'h0, fmt.fixed_point_numeric_format,
                3'h0, fmt.max_digits, fmt.min_digits};
        end
    end

    // read data is loaded in the setup cycle so the access needs no wait
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (setup_rd) begin
            prdata <= rd_word;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            header_on <= 1'b0;
            inst_state <= ST_READY;
            arg <= '0;
            fmt_kind <= 3'h0;
        end else if (wr && full_word) begin
            if (hit_ctrl) begin
                header_on <= pwdata[0];
                inst_state <= inst_state_t'(pwdata[4:1]);
            end
            if (hit_arg) begin
                arg <= arg_t'(pwdata[20:0]);
            end
            if (hit_fmt) begin
                fmt_kind <= pwdata[2:0];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            settings <= SETTINGS_RESET;
            fmt <= '0;
        end else begin
            settings <= next_settings;
            fmt <= next_fmt;
        end
    end

    // event flags: hardware set wins over a write-one clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmd_err_flag <= 1'b0;
            exe_err_flag <= 1'b0;
            power_on_flag <= 1'b1;
        end else begin
            cmd_err_flag <= set_cmd_err || (cmd_err_flag
                && !(clr_status && pwdata[STAT_CMD_ERR]));
            exe_err_flag <= set_exe_err || (exe_err_flag
                && !(clr_status && pwdata[STAT_EXE_ERR]));
            power_on_flag <= power_on_flag && !(clr_status && pwdata[STAT_POWER_ON]);
        end
    end

    // answer appears only once the query message is complete
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            resp <= '0;
            resp_valid <= 1'b0;
        end else begin
            if (do_query) begin
                resp <= next_resp;
            end
            resp_valid <= do_query || (resp_valid && !rd_resp);
        end
    end

    // run settings are sampled at start and held through the test
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_start <= 1'b0;
            run_pulse_en <= 1'b0;
            run_timer_en <= 1'b0;
            run_limit_volt <= 1'b0;
            run_upper_en <= 1'b0;
            run_count_apply <= 1'b0;
        end else begin
            run_start <= link_start || panel_start;
            if (link_start || panel_start) begin
                run_pulse_en <= settings.pulse_out && !link_start;
                run_timer_en <= settings.timer_en && !settings.endless;
                run_limit_volt <= settings.unit_volt;
                run_upper_en <= settings.upper_en;
                run_count_apply <= settings.count_en;
            end
        end
    end

    a_cont_no_pulse: assert property (@(posedge pclk) disable iff (!presetn)
        settings.test_mode == MODE_CONT |-> !settings.pulse_out)
        else $error("pulse output enabled in continuous mode");

    a_state_gate: assert property (@(posedge pclk) disable iff (!presetn)
        exec && !is_query && !bad_cmd && !state_ok |=> exe_err_flag && $stable(settings))
        else $error("setting accepted outside ready or option screen");

    a_range_reject: assert property (@(posedge pclk) disable iff (!presetn)
        exec && !is_query && op_num && !num_ok |=> exe_err_flag && $stable(settings))
        else $error("out of range value not rejected");

    a_round_apply: assert property (@(posedge pclk) disable iff (!presetn)
        apply && op_raw == OP_LATCH
        |=> settings.pass_fail_latch_option == $past(rounded[1:0]))
        else $error("rounded latch value not stored");

    a_char_reject: assert property (@(posedge pclk) disable iff (!presetn)
        exec && !is_query && op_char && !char_ok |=> cmd_err_flag && !$rose(exe_err_flag))
        else $error("bad word not reported as command error");

    a_link_no_pulse: assert property (@(posedge pclk) disable iff (!presetn)
        link_start |=> run_start && !run_pulse_en)
        else $error("link start kept pulse output");

    a_endless_timer: assert property (@(posedge pclk) disable iff (!presetn)
        (link_start || panel_start) && settings.endless |=> !run_timer_en)
        else $error("duration enable used under endless option");

    a_query_stable: assert property (@(posedge pclk) disable iff (!presetn)
        do_query |=> $stable(settings) && resp_valid && resp.path == $past(op_raw))
        else $error("query changed a setting or gave no answer");

    a_resp_header: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(resp_valid) |-> resp.header_on == $past(header_on))
        else $error("response header mark wrong");

    a_power_flag: assert property (@(posedge pclk) disable iff (!presetn)
        $fell(power_on_flag) |-> $past(clr_status && pwdata[STAT_POWER_ON]))
        else $error("power-on flag lost without a clear");

endmodule : tester_option_command_set

/* verif/apb_host.sv */
// Purpose: APB requester standing in for the host computer
// Assumes: each call starts right after a rising edge of pclk
// Notes: wait for pready is bounded; released write data shows the inverse
`timescale 1ns/10ps
module apb_host (
    input wire logic pclk,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata,
    output logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        pstrb = 4'h0;
    end

    task automatic xfer(input logic wr, input logic [7:0] addr, input logic [31:0] data,
        output logic [31:0] rdata, output logic err);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= data;
        pstrb <= 4'hF;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 64);
        rdata = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // a stale value would hide a slave that samples data late
        pwdata <= ~data;
    endtask : xfer
endmodule : apb_host

/* verif/tb.sv */
// Purpose: self-checking bench for the option command interpreter
// Assumes: zero-wait APB slave, commands as ARG then CMD writes
// Notes: expected settings come from a bench model, errors cleared after each check
`timescale 1ns/10ps
module tb
    import tester_option_pkg::*;
;
    logic pclk, presetn, panel_start, psel, penable, pwrite, pready, pslverr, er, hdr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] pstrb, st;
    logic run_start, run_pulse_en, run_timer_en, run_limit_volt, run_upper_en;
    logic run_count_apply;
    int err_count, n_compared, cycles;
    integer seed;
    settings_t exp_set;
    logic [3:0] optab [9] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8};
    logic [3:0] sttab [4] = '{4'h1, 4'h2, 4'h4, 4'h8};
    logic [11:0] fmttab [5] = '{12'h132, 12'h333, 12'h544, 12'h742, 12'h821};

    tester_option_command_set dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .panel_start(panel_start),
        .run_start(run_start), .run_pulse_en(run_pulse_en), .run_timer_en(run_timer_en),
        .run_limit_volt(run_limit_volt), .run_upper_en(run_upper_en),
        .run_count_apply(run_count_apply));
    apb_host host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr));

    always #10 pclk = ~pclk;

    task automatic stop_test();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : stop_test

    always @(posedge pclk) begin
        cycles++;
        if (cycles == 30000) begin
            err_count++;
            $display("[ERR] run length expected below 30000 seen 30000");
            stop_test();
        end
    end

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        host.xfer(1'b1, a, d, rd, er);
    endtask : wr

    task automatic rdr(input logic [7:0] a);
        host.xfer(1'b0, a, 32'h0, rd, er);
    endtask : rdr

    task automatic ctrl(input logic h, input logic [3:0] s);
        hdr = h;
        st = s;
        wr(OFS_CTRL, {27'h0, s, h});
    endtask : ctrl

    // returns exe and cmd error bits; updates the expected settings when accepted
    function automatic logic [1:0] model(input logic [3:0] op, input arg_t a);
        logic [8:0] v;
        logic ok;
        v = {1'b0, a.value_int} + {8'h0, a.value_frac[7]};
        ok = (st == 4'h1) || (st == 4'h2);
        if (op == 4'h4 || op == 4'h5 || op == 4'h6) begin
            if (!a.is_char) return 2'b01;
            if (op == 4'h5 && a.word != WORD_OHM && a.word != WORD_VOLT) return 2'b01;
            if (op != 4'h5 && a.word != WORD_ON && a.word != WORD_OFF) return 2'b01;
            if (!ok) return 2'b10;
            if (op == 4'h4) exp_set.timer_en = (a.word == WORD_ON);
            if (op == 4'h5) exp_set.unit_volt = (a.word == WORD_VOLT);
            if (op == 4'h6) exp_set.upper_en = (a.word == WORD_ON);
            return 2'b00;
        end
        if (a.is_char || !ok) return 2'b10;
        case (op)
            4'h0: if (v > MAX_BINARY || (v[0] && exp_set.test_mode == MODE_CONT)) return 2'b10;
            4'h1: if (v > MAX_LATCH) return 2'b10;
            4'h2, 4'h3: if (v > MAX_PRINT) return 2'b10;
            default: if (v > MAX_BINARY) return 2'b10;
        endcase
        case (op)
            4'h0: exp_set.pulse_out = v[0];
            4'h1: exp_set.pass_fail_latch_option = v[1:0];
            4'h2: exp_set.print_mode = v[1:0];
            4'h3: exp_set.test_mode = v[1:0];
            4'h7: exp_set.endless = v[0];
            default: exp_set.count_en = v[0];
        endcase
        if (op == 4'h3 && v[1:0] == MODE_CONT) exp_set.pulse_out = 1'b0;
        return 2'b00;
    endfunction : model

    function automatic logic [16:0] qval(input logic [3:0] op);
        case (op)
            4'h0: return {16'h0, exp_set.pulse_out};
            4'h1: return {15'h0, exp_set.pass_fail_latch_option};
            4'h2: return {15'h0, exp_set.print_mode};
            4'h3: return {15'h0, exp_set.test_mode};
            4'h4: return {13'h1000, exp_set.timer_en ? WORD_ON : WORD_OFF};
            4'h5: return {13'h1000, exp_set.unit_volt ? WORD_VOLT : WORD_OHM};
            4'h6: return {13'h1000, exp_set.upper_en ? WORD_ON : WORD_OFF};
            4'h7: return {16'h0, exp_set.endless};
            default: return {16'h0, exp_set.count_en};
        endcase
    endfunction : qval

    task automatic cmd(input logic [3:0] op, input logic [20:0] a);
        logic [1:0] e;
        e = model(op, arg_t'(a));
        wr(OFS_ARG, {11'h0, a});
        wr(OFS_CMD, {27'h0, 1'b0, op});
        rdr(OFS_STATUS);
        chk("error flags", {30'h0, e}, {30'h0, rd[1:0]});
        wr(OFS_STATUS, 32'h3);
        rdr(OFS_SETTINGS);
        chk("settings", {20'h0, exp_set}, rd);
    endtask : cmd

    task automatic query(input logic [3:0] op);
        logic [16:0] q;
        q = qval(op);
        wr(OFS_CMD, {27'h0, 1'b1, op});
        rdr(OFS_STATUS);
        chk("answer flag", 32'h4, {29'h0, rd[2:0]});
        rdr(OFS_RESP);
        chk("response", {10'h0, hdr, q[16], op, q[15:0]},
            {10'h0, rd[31:30], rd[27:24], rd[15:0]});
        rdr(OFS_SETTINGS);
        chk("settings after query", {20'h0, exp_set}, rd);
    endtask : query

    task automatic go(input logic link);
        logic ran;
        ran = !link || st == 4'h1;
        if (link) begin
            wr(OFS_CMD, {27'h0, 1'b0, 4'h9});
        end else begin
            @(posedge pclk);
            panel_start <= 1'b1;
            @(posedge pclk);
            panel_start <= 1'b0;
        end
        #1;
        chk("run start", {31'h0, ran}, {31'h0, run_start});
        if (ran) chk("run levels", {27'h0, exp_set.pulse_out & !link,
            exp_set.timer_en & !exp_set.endless, exp_set.unit_volt, exp_set.upper_en,
            exp_set.count_en}, {27'h0, run_pulse_en, run_timer_en, run_limit_volt,
            run_upper_en, run_count_apply});
    endtask : go

    task automatic power_on();
        exp_set = SETTINGS_RESET;
        hdr = 1'b0;
        st = 4'h1;
        presetn <= 1'b0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        rdr(OFS_STATUS);
        chk("status at power-on", 32'h80, rd);
        rdr(OFS_SETTINGS);
        chk("settings at power-on", {20'h0, SETTINGS_RESET}, rd);
        wr(OFS_STATUS, 32'h80);
    endtask : power_on

    initial begin
        logic [31:0] r;
        pclk = 1'b0;
        presetn = 1'b0;
        panel_start = 1'b0;
        seed = 23;
        err_count = 0;
        n_compared = 0;
        cycles = 0;
        power_on();
        rdr(8'h1C);
        chk("unmapped read", 32'h1, {rd[30:0], er});
        $display("test reset done");
        cmd(4'h0, 21'h00100);
        cmd(4'h3, 21'h00180);
        cmd(4'h0, 21'h000C0);
        cmd(4'h1, 21'h0037F);
        cmd(4'h1, 21'h00380);
        cmd(4'h2, 21'h00200);
        cmd(4'h2, 21'h00300);
        cmd(4'h4, 21'h130000);
        cmd(4'h5, 21'h00100);
        cmd(4'h5, 21'h140000);
        ctrl(1'b0, 4'h4);
        cmd(4'h6, 21'h110000);
        ctrl(1'b1, 4'h2);
        $display("test corner commands done");
        for (int i = 0; i < 60; i++) begin
            r = $random(seed);
            if (r[31:29] == 3'h0) ctrl(r[28], sttab[r[27:26]]);
            cmd(optab[r[25:22] % 9], {r[20], 1'b0, r[18:16], 5'h0, r[10:8], r[7:0]});
            if (r[21]) query(optab[r[25:22] % 9]);
        end
        $display("test random commands done");
        for (int i = 0; i < 9; i++) begin
            ctrl(i[0], 4'h8);
            query(optab[i]);
        end
        $display("test queries done");
        ctrl(1'b0, 4'h1);
        cmd(4'h3, 21'h00100);
        cmd(4'h0, 21'h00100);
        cmd(4'h7, 21'h00100);
        cmd(4'h4, 21'h110000);
        cmd(4'h8, 21'h00100);
        go(1'b1);
        go(1'b0);
        cmd(4'h7, 21'h00000);
        cmd(4'h5, 21'h130000);
        go(1'b0);
        ctrl(1'b0, 4'h2);
        go(1'b1);
        $display("test start done");
        for (int k = 0; k < 5; k++) begin
            wr(OFS_FMT, k);
            @(posedge pclk);
            rdr(OFS_FMT);
            // the fixed-point mark sits at bit 11 of the read word
            chk("format", {20'h0, fmttab[k]},
                {20'h0, rd[18:16], rd[11], rd[7:0]});
        end
        $display("test formats done");
        power_on();
        $display("test second reset done");
        stop_test();
    end
endmodule : tb
